// ===== hw/pcort_top.sv
// performance counters with overflow interrupt and retire tagging
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "pcort_defines.svh"
module pcort_top (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        NRST,
	// AXI4-Lite write address
	input  wire logic [7:0]  AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	// AXI4-Lite write data
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	// AXI4-Lite write response
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	// AXI4-Lite read
	input  wire logic [7:0]  ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]      RRESP,
	output logic             RVALID,
	input  wire logic        RREADY,
	// core events, one pulse per cycle each
	input  wire logic        RAW_EVENT,
	input  wire logic        UOP_ALLOC,
	input  wire logic        FRONT_HIT,
	input  wire logic        EXEC_HIT,
	input  wire logic        REPLAY_HIT,
	input  wire logic        BRANCH_MISPREDICT,
	input  wire logic        UOP_RETIRE,
	input  wire logic        UOP_CANCEL,
	input  wire logic        INSTR_RETIRE,
	// to the local interrupt controller vector entry
	output logic             COUNTER_OVERFLOW_INTERRUPT
);
	localparam int N = `PCORT_NCNT;

	// per-counter control registers and state
	logic [`PCORT_CTRL_W-1:0] ctrl_r [N];
	logic [`PCORT_CNT_W-1:0]  count  [N];
	logic [N-1:0]             flag;
	logic [N-1:0]             irq;
	logic [N-1:0]             inc;
	logic [N-1:0]             ld_lo;
	logic [N-1:0]             ld_hi;
	logic [N-1:0]             clr;

	// tag classification pulses
	logic front_ret;
	logic exec_ret;
	logic replay_ret;
	logic front_bog;
	logic exec_bog;
	logic replay_bog;

	// RL13 four mechanisms
	// RL14 front-end tag slot
	pcort_tagger u_front (
		.CLK           (CLK),
		.NRST          (NRST),
		.alloc         (UOP_ALLOC),
		.event_hit     (FRONT_HIT),
		.retire        (UOP_RETIRE),
		.cancel        (UOP_CANCEL),
		.tagged_retire (front_ret),
		.tagged_bogus  (front_bog)
	);
	// RL15 execution tag slot
	pcort_tagger u_exec (
		.CLK           (CLK),
		.NRST          (NRST),
		.alloc         (UOP_ALLOC),
		.event_hit     (EXEC_HIT),
		.retire        (UOP_RETIRE),
		.cancel        (UOP_CANCEL),
		.tagged_retire (exec_ret),
		.tagged_bogus  (exec_bog)
	);
	// RL16 replay and mispredict tag
	pcort_tagger u_replay (
		.CLK           (CLK),
		.NRST          (NRST),
		.alloc         (UOP_ALLOC),
		.event_hit     (REPLAY_HIT | BRANCH_MISPREDICT),
		.retire        (UOP_RETIRE),
		.cancel        (UOP_CANCEL),
		.tagged_retire (replay_ret),
		.tagged_bogus  (replay_bog)
	);

	// bus decode
	logic [7:0]  aw_r;
	logic [31:0] wd_r;
	logic        aw_ok_r;
	logic        w_ok_r;
	logic        wr_go;
	logic        wr_hit;
	logic [2:0]  wr_idx;
	logic [2:0]  rd_idx;
	logic [31:0] rd_val;
	logic        rd_hit;

	assign AWREADY = !aw_ok_r && !BVALID;
	assign WREADY  = !w_ok_r && !BVALID;
	assign wr_go   = aw_ok_r && w_ok_r;
	assign wr_idx  = aw_r[4:2];
	assign rd_idx  = ARADDR[4:2];
	assign ARREADY = !RVALID;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_cnt
			logic [`PCORT_SEL_W-1:0] sel;
			logic                    ret_mode;
			logic                    ev;
			assign sel      = ctrl_r[g][`PCORT_SEL_LSB +: `PCORT_SEL_W];
			assign ret_mode = ctrl_r[g][`PCORT_B_RETIRE];
			// RL10 retire mode drops bogus work
			// RL19 untagged retired counts
			assign ev =
				(sel == pcort_pkg::PCORT_EV_RAW)    ? RAW_EVENT :
				(sel == pcort_pkg::PCORT_EV_FRONT)  ?
					(ret_mode ? front_ret : front_ret | front_bog) :
				(sel == pcort_pkg::PCORT_EV_EXEC)   ?
					(ret_mode ? exec_ret : exec_ret | exec_bog) :
				(sel == pcort_pkg::PCORT_EV_REPLAY) ?
					(ret_mode ? replay_ret : replay_ret | replay_bog) :
				(sel == pcort_pkg::PCORT_EV_INSTR)  ? INSTR_RETIRE :
				(sel == pcort_pkg::PCORT_EV_UOPS)   ?
					(ret_mode ? UOP_RETIRE : UOP_RETIRE | UOP_CANCEL) :
				1'b0;
			// RL9 null event never counts
			assign inc[g]   = ev;
			assign ld_lo[g] = wr_go && aw_r[7:5] == 3'h1 && wr_idx == 3'(g);
			assign ld_hi[g] = wr_go && aw_r[7:5] == 3'h2 && wr_idx == 3'(g);
			// writing a 1 to a status bit clears that flag
			assign clr[g]   = wr_go && aw_r == `PCORT_STATUS && wd_r[g];

			// RL5 wrap then first event
			pcort_counter u_cnt (
				.CLK             (CLK),
				.NRST            (NRST),
				.enable          (ctrl_r[g][`PCORT_B_EN]),
				.ovi_en          (ctrl_r[g][`PCORT_B_OVI]),
				.force_overflow  (ctrl_r[g][`PCORT_B_FORCE]),
				.inc             (inc[g]),
				.load_lo         (ld_lo[g]),
				.load_hi         (ld_hi[g]),
				.wdata           (wd_r),
				.flag_clr        (clr[g]),
				.count_r         (count[g]),
				.overflow_flag_r (flag[g]),
				.irq_r           (irq[g])
			);

			// control register write
			always_ff @(posedge CLK or negedge NRST) begin
				if (!NRST) begin
					ctrl_r[g] <= '0;
				end else if (wr_go && aw_r[7:5] == 3'h0 &&
					wr_idx == 3'(g)) begin
					ctrl_r[g] <= wd_r[`PCORT_CTRL_W-1:0];
				end
			end
		end
	endgenerate

	// RL1 per-counter request
	// RL3 merged to controller
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			COUNTER_OVERFLOW_INTERRUPT <= 1'b0;
		end else begin
			COUNTER_OVERFLOW_INTERRUPT <= |irq;
		end
	end

	// write channel capture, either order
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			aw_r    <= 8'h00;
			wd_r    <= 32'h0000_0000;
			aw_ok_r <= 1'b0;
			w_ok_r  <= 1'b0;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_r    <= AWADDR;
				aw_ok_r <= 1'b1;
			end else if (wr_go) begin
				aw_ok_r <= 1'b0;
			end
			if (WVALID && WREADY) begin
				wd_r   <= WDATA;
				w_ok_r <= 1'b1;
			end else if (wr_go) begin
				w_ok_r <= 1'b0;
			end
		end
	end

	// write hits: ctrl, count lo, count hi, status
	assign wr_hit = (aw_r[7:5] <= 3'h2 && aw_r[4:2] < 3'(N) &&
		aw_r[1:0] == 2'b00) || aw_r == `PCORT_STATUS;

	// write response; partial strobes are taken as full words
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			BVALID <= 1'b0;
			BRESP  <= `PCORT_RESP_OK;
		end else if (wr_go) begin
			BVALID <= 1'b1;
			BRESP  <= wr_hit ? `PCORT_RESP_OK : `PCORT_RESP_ERR;
		end else if (BREADY) begin
			BVALID <= 1'b0;
		end
	end

	// read mux
	logic [`PCORT_CNT_W-1:0] rc;
	assign rc = count[rd_idx[1:0]];
	// RL4 flags readable per counter
	assign rd_hit = (ARADDR[7:5] <= 3'h2 && rd_idx < 3'(N)) ||
		ARADDR == `PCORT_STATUS || ARADDR == `PCORT_ID;
	assign rd_val =
		(ARADDR == `PCORT_STATUS) ? {28'h000_0000, flag} :
		(ARADDR == `PCORT_ID)     ? `PCORT_ID_VAL :
		(ARADDR[7:5] == 3'h0)     ?
			{25'h000_0000, ctrl_r[rd_idx[1:0]]} :
		(ARADDR[7:5] == 3'h1)     ? rc[31:0] :
		{24'h00_0000, rc[`PCORT_CNT_W-1:32]};

	// read response
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			RVALID <= 1'b0;
			RDATA  <= 32'h0000_0000;
			RRESP  <= `PCORT_RESP_OK;
		end else if (ARVALID && ARREADY) begin
			RVALID <= 1'b1;
			RDATA  <= rd_hit ? rd_val : 32'h0000_0000;
			RRESP  <= rd_hit ? `PCORT_RESP_OK : `PCORT_RESP_ERR;
		end else if (RREADY) begin
			RVALID <= 1'b0;
		end
	end

	// event selects of the first and last counter, watched below
	logic [`PCORT_SEL_W-1:0] chk_sel0;
	logic [`PCORT_SEL_W-1:0] chk_sel3;
	logic                    chk_ret0;
	logic                    chk_ret3;
	assign chk_sel0 = ctrl_r[0][`PCORT_SEL_LSB +: `PCORT_SEL_W];
	assign chk_sel3 = ctrl_r[N-1][`PCORT_SEL_LSB +: `PCORT_SEL_W];
	assign chk_ret0 = ctrl_r[0][`PCORT_B_RETIRE];
	assign chk_ret3 = ctrl_r[N-1][`PCORT_B_RETIRE];

	// RL3 request only from a counter
	property p_irq;
		@(posedge CLK) disable iff (!NRST)
		COUNTER_OVERFLOW_INTERRUPT |-> $past(|irq);
	endproperty
	a_irq: assert property (p_irq) // RL3
		else $error("spurious interrupt");

	// RL3 every counter request delivered
	property p_irq_out;
		@(posedge CLK) disable iff (!NRST)
		|irq |=> COUNTER_OVERFLOW_INTERRUPT;
	endproperty
	a_irq_out: assert property (p_irq_out) // RL3
		else $error("counter request lost");

	// RL9 null event never counts
	property p_nullev;
		@(posedge CLK) disable iff (!NRST)
		chk_sel0 == pcort_pkg::PCORT_EV_NONE |-> !inc[0];
	endproperty
	a_nullev: assert property (p_nullev) // RL9
		else $error("null event counted");

	// RL10 bogus op not counted
	property p_bogus;
		@(posedge CLK) disable iff (!NRST)
		chk_ret3 && UOP_CANCEL && !UOP_RETIRE &&
		chk_sel3 == pcort_pkg::PCORT_EV_UOPS |-> !inc[N-1];
	endproperty
	a_bogus: assert property (p_bogus) // RL10
		else $error("bogus op counted");

	// RL14 front-end tags at retirement
	property p_front;
		@(posedge CLK) disable iff (!NRST)
		chk_ret0 && chk_sel0 == pcort_pkg::PCORT_EV_FRONT |->
			inc[0] == front_ret;
	endproperty
	a_front: assert property (p_front) // RL14
		else $error("front-end tag count wrong");

	// RL10 outside retire mode all tagged ops count
	property p_front_all;
		@(posedge CLK) disable iff (!NRST)
		!chk_ret0 && chk_sel0 == pcort_pkg::PCORT_EV_FRONT |->
			inc[0] == (front_ret | front_bog);
	endproperty
	a_front_all: assert property (p_front_all) // RL10
		else $error("speculative tag count wrong");

	// RL19 retired instructions untagged
	property p_instr;
		@(posedge CLK) disable iff (!NRST)
		chk_sel3 == pcort_pkg::PCORT_EV_INSTR |-> inc[N-1] == INSTR_RETIRE;
	endproperty
	a_instr: assert property (p_instr) // RL19
		else $error("retired instruction count wrong");

	// RL19 retired micro-ops untagged
	property p_uops;
		@(posedge CLK) disable iff (!NRST)
		chk_ret3 && chk_sel3 == pcort_pkg::PCORT_EV_UOPS |->
			inc[N-1] == UOP_RETIRE;
	endproperty
	a_uops: assert property (p_uops) // RL19
		else $error("retired micro-op count wrong");

	// RL4 status shows every flag
	property p_status;
		@(posedge CLK) disable iff (!NRST)
		ARVALID && ARREADY && ARADDR == `PCORT_STATUS |=>
			RDATA == {28'h000_0000, $past(flag)};
	endproperty
	a_status: assert property (p_status) // RL4
		else $error("status read wrong");

	// write answered one cycle after both halves
	property p_wresp;
		@(posedge CLK) disable iff (!NRST)
		wr_go |=> BVALID;
	endproperty
	a_wresp: assert property (p_wresp)
		else $error("write response missing");

	// read answered one cycle after the address
	property p_rresp;
		@(posedge CLK) disable iff (!NRST)
		ARVALID && ARREADY |=> RVALID;
	endproperty
	a_rresp: assert property (p_rresp)
		else $error("read response missing");
endmodule // pcort_top

// ===== hw/pcort_defines.svh
// constants for the performance counter overflow and retire-tag block
// Summary of operation
// RL1 - each counter may request overflow interrupt
// RL2 - interrupt only when enable flag set
// RL3 - interrupt goes to local interrupt controller
// RL4 - each counter exposes its own overflow flag
// RL5 - interrupt on first event after wrap
// RL6 - software presets minus count plus one
// RL7 - force overflow flags every increment
// RL8 - software enables a counter per selector
// RL9 - software selects a real event
// RL10 - retire mode counts committed work only
// RL11 - micro-op is bogus or retired, never both
// RL12 - tag once, count once at retirement
// RL13 - four independent tagging mechanisms
// RL14 - front-end tags counted by front-end event
// RL15 - execution tags counted by execution event
// RL16 - replay tags include mispredicted branches
// RL17 - counter wraps and sets overflow flag
// RL18 - overflow flag sticky until cleared
// RL19 - fourth mechanism counts retired events untagged
// RL20 - one request per overflow, flag already set
`ifndef PCORT_DEFINES_SVH
`define PCORT_DEFINES_SVH
`define PCORT_NCNT        4
`define PCORT_CNT_W       40
`define PCORT_ADDR_W      8
`define PCORT_CTRL_BASE   8'h00
`define PCORT_CNT_LO_BASE 8'h20
`define PCORT_CNT_HI_BASE 8'h40
`define PCORT_STATUS      8'h60
`define PCORT_ID          8'h64
`define PCORT_ID_VAL      32'h0000_5a5a // arbitrary value, names no maker
`define PCORT_B_EN        0
`define PCORT_B_OVI       1
`define PCORT_B_FORCE     2
`define PCORT_B_RETIRE    3
`define PCORT_SEL_LSB     4
`define PCORT_SEL_W       3
`define PCORT_CTRL_W      7
`define PCORT_RESP_OK     2'b00
`define PCORT_RESP_ERR    2'b10
`endif

// ===== hw/pcort_pkg.sv
// types for the performance counter overflow and retire-tag block
package pcort_pkg;
	// event selection: 0 is the null event
	typedef enum logic [2:0] {
		PCORT_EV_NONE   = 3'h0,
		PCORT_EV_RAW    = 3'h1,
		PCORT_EV_FRONT  = 3'h2,
		PCORT_EV_EXEC   = 3'h3,
		PCORT_EV_REPLAY = 3'h4,
		PCORT_EV_INSTR  = 3'h5,
		PCORT_EV_UOPS   = 3'h6
	} pcort_event_t;
	// bus slave states
	typedef enum logic [2:0] {
		PCORT_S_IDLE = 3'b001,
		PCORT_S_RESP = 3'b010,
		PCORT_S_HOLD = 3'b100
	} pcort_bstate_t;
endpackage : pcort_pkg

// ===== hw/pcort_tagger.sv
// one retire-tag slot: tags a micro-op once, classifies it at commit
`timescale 1ns/1ps
`include "pcort_defines.svh"
module pcort_tagger (
	// clock and reset
	input  wire logic CLK,
	input  wire logic NRST,
	// life-cycle of the tracked micro-op
	input  wire logic alloc,
	input  wire logic event_hit,
	input  wire logic retire,
	input  wire logic cancel,
	// classification pulses
	output logic      tagged_retire,
	output logic      tagged_bogus
);
	logic tag_r;
	logic tag_nxt;
	logic done;

	assign done = retire | cancel;
	// RL12 tag only once
	assign tag_nxt = alloc ? event_hit : (done ? 1'b0 : (tag_r | event_hit));

	// repeat hits leave the tag set, so the slot counts once
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			tag_r <= 1'b0;
		end else begin
			tag_r <= tag_nxt;
		end
	end

	// RL11 retire beats cancel
	assign tagged_retire = retire & (tag_r | event_hit);
	assign tagged_bogus  = cancel & ~retire & (tag_r | event_hit);

	// RL12 one count per tagged op
	property p_once;
		@(posedge CLK) disable iff (!NRST)
		tagged_retire |=> !tagged_retire || $past(alloc) || tag_r == 1'b0;
	endproperty
	a_once: assert property (p_once) // RL12
		else $error("tag counted twice");

	// RL11 bogus or retired, never both
	property p_excl;
		@(posedge CLK) disable iff (!NRST)
		!(tagged_retire && tagged_bogus);
	endproperty
	a_excl: assert property (p_excl) // RL11
		else $error("op both bogus and retired");
endmodule // pcort_tagger

// ===== hw/pcort_counter.sv
// one counter: wrap, sticky overflow flag, interrupt request pulse
`timescale 1ns/1ps
`include "pcort_defines.svh"
module pcort_counter (
	// clock and reset
	input  wire logic                    CLK,
	input  wire logic                    NRST,
	// control
	input  wire logic                    enable,
	input  wire logic                    ovi_en,
	input  wire logic                    force_overflow,
	input  wire logic                    inc,
	// software load and clear
	input  wire logic                    load_lo,
	input  wire logic                    load_hi,
	input  wire logic [31:0]             wdata,
	input  wire logic                    flag_clr,
	// state
	output logic [`PCORT_CNT_W-1:0]      count_r,
	output logic                         overflow_flag_r,
	output logic                         irq_r
);
	logic [`PCORT_CNT_W-1:0] count_nxt;
	logic                    step;
	logic                    wrap;
	logic                    ovf_ev;
	logic                    late_ev;
	logic                    irq_ev;
	logic                    armed_r;
	logic                    armed_nxt;
	logic                    flag_nxt;

	assign step = enable & inc;
	// RL17 wrap past maximum
	assign wrap = step & (&count_r);
	// RL7 force overflow each step
	assign ovf_ev = wrap | (step & force_overflow);
	// RL5 interrupt on the event after a wrap
	// so a preset of minus n plus one interrupts exactly on event n
	assign late_ev = step & armed_r;
	assign irq_ev  = late_ev | (step & force_overflow);
	// a new preset drops a pending wrap: the count no longer belongs to it
	assign armed_nxt = (load_lo | load_hi) ? 1'b0 :
		wrap ? 1'b1 : (step ? 1'b0 : armed_r);
	assign count_nxt = load_lo ? {count_r[`PCORT_CNT_W-1:32], wdata} :
		load_hi ? {wdata[`PCORT_CNT_W-33:0], count_r[31:0]} :
		step ? count_r + 1'b1 : count_r;
	// RL18 sticky, set beats clear
	// RL20 the interrupting event marks the flag again
	assign flag_nxt = ovf_ev | (late_ev & ovi_en) |
		(overflow_flag_r & ~flag_clr);

	// interrupt is registered with the flag so the flag is visible in the same cycle
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			count_r         <= '0;
			overflow_flag_r <= 1'b0;
			armed_r         <= 1'b0;
			irq_r           <= 1'b0;
		end else begin
			count_r         <= count_nxt;
			overflow_flag_r <= flag_nxt;
			armed_r         <= armed_nxt;
			// RL2 gated by enable flag
			irq_r           <= irq_ev & ovi_en;
		end
	end

	// RL20 flag visible with request
	property p_flag;
		@(posedge CLK) disable iff (!NRST)
		irq_r |-> overflow_flag_r;
	endproperty
	a_flag: assert property (p_flag) // RL20
		else $error("irq without flag");

	// RL1 request follows its event
	property p_pulse;
		@(posedge CLK) disable iff (!NRST)
		irq_ev && ovi_en |=> irq_r;
	endproperty
	a_pulse: assert property (p_pulse) // RL1
		else $error("missing irq on overflow");

	// RL2 no request while disabled
	property p_gate;
		@(posedge CLK) disable iff (!NRST)
		irq_r |-> $past(ovi_en);
	endproperty
	a_gate: assert property (p_gate) // RL2
		else $error("irq while disabled");

	// RL17 wrap to zero with flag
	property p_wrap;
		@(posedge CLK) disable iff (!NRST)
		wrap && !load_lo && !load_hi |=> count_r == '0 && overflow_flag_r;
	endproperty
	a_wrap: assert property (p_wrap) // RL17
		else $error("wrap wrong");

	// RL7 forced overflow sets flag
	property p_force;
		@(posedge CLK) disable iff (!NRST)
		step && force_overflow |=> overflow_flag_r;
	endproperty
	a_force: assert property (p_force) // RL7
		else $error("force overflow ignored");

	// RL18 flag holds until cleared
	property p_stick;
		@(posedge CLK) disable iff (!NRST)
		overflow_flag_r && !flag_clr |=> overflow_flag_r;
	endproperty
	a_stick: assert property (p_stick) // RL18
		else $error("flag dropped");

	// RL5 wrap arms, the next event interrupts
	sequence s_wrapped;
		wrap && !force_overflow && !load_lo && !load_hi;
	endsequence
	sequence s_armed_ev;
		armed_r && step && ovi_en;
	endsequence
	property p_early;
		@(posedge CLK) disable iff (!NRST)
		s_wrapped |=> !irq_r;
	endproperty
	a_early: assert property (p_early) // RL5
		else $error("irq on the wrapping event");
	property p_arm;
		@(posedge CLK) disable iff (!NRST)
		s_wrapped |=> armed_r;
	endproperty
	a_arm: assert property (p_arm) // RL5
		else $error("wrap not remembered");
	property p_late;
		@(posedge CLK) disable iff (!NRST)
		s_armed_ev |=> irq_r;
	endproperty
	a_late: assert property (p_late) // RL5
		else $error("no irq on event after wrap");
endmodule // pcort_counter

// ===== bench/pcort_lic_model.sv
// stand-in for the local interrupt controller: counts overflow requests
`timescale 1ns/1ps
module pcort_lic_model (
	// clock and reset
	input  wire logic CLK,
	input  wire logic NRST,
	// request line from the counter block
	input  wire logic irq_in,
	// requests handed on to the core so far
	output int        taken
);
	// vector entry delivery
	// a pulse needs no acknowledge, so every high cycle is one request
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			taken <= 0;
		end else if (irq_in === 1'b1) begin
			taken <= taken + 1;
		end
	end
endmodule // pcort_lic_model

// ===== bench/pcort_top_bench.sv
// self-checking bench for the counter overflow and retire-tag block
`timescale 1ns/1ps
module pcort_top_bench;
	logic                 CLK, NRST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
	logic                 AWREADY, WREADY, BVALID, ARREADY, RVALID, irq;
	logic [7:0]           AWADDR, ARADDR;
	logic [31:0]          WDATA, RDATA;
	logic [1:0]           BRESP, RRESP;
	logic [8:0]           evs;
	int                   taken, miscompares, total_checks, cycles, k, h;
	logic [1:0]           bq[$];
	logic [33:0]          rq[$];
	pcort_pkg::pcort_event_t sel[4] = '{pcort_pkg::PCORT_EV_FRONT,
		pcort_pkg::PCORT_EV_EXEC, pcort_pkg::PCORT_EV_REPLAY,
		pcort_pkg::PCORT_EV_UOPS};
	int                   cnt_e[4] = '{1, 1, 1, 3};
	// alloc, front hits, exec hit, retire; bogus op; mispredict; plain op
	logic [8:0]           seq[12] = '{9'h080, 9'h040, 9'h020, 9'h004,
		9'h080, 9'h050, 9'h002, 9'h080, 9'h008, 9'h004, 9'h080, 9'h004};

	pcort_top uut (.CLK(CLK), .NRST(NRST), .AWADDR(AWADDR),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
		.WSTRB(4'hf), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
		.BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
		.ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
		.RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.RAW_EVENT(evs[8]), .UOP_ALLOC(evs[7]), .FRONT_HIT(evs[6]),
		.EXEC_HIT(evs[5]), .REPLAY_HIT(evs[4]),
		.BRANCH_MISPREDICT(evs[3]), .UOP_RETIRE(evs[2]),
		.UOP_CANCEL(evs[1]), .INSTR_RETIRE(evs[0]),
		.COUNTER_OVERFLOW_INTERRUPT(irq));
	pcort_lic_model lic (.CLK(CLK), .NRST(NRST), .irq_in(irq),
		.taken(taken));

	// clock generation
	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end

	// hang guard, well above the few hundred cycles the tests need
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			give_verdict();
		end
	end

	// scoreboard: oldest note is compared when a response shows
	always @(posedge CLK) begin
		if (NRST && BVALID && BREADY)
			cmp({BRESP, 32'h0000_0000}, {bq.pop_front(), 32'h0000_0000});
		if (NRST && RVALID && RREADY)
			cmp({RRESP, RDATA}, rq.pop_front());
	end

	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t: bus got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_irq(input int exp);
		total_checks++;
		if (taken != exp) begin
			miscompares++;
			$display("ERROR %0t: irqs %0d expected %0d", $time, taken, exp);
		end
	endtask

	// write: both channels offered together, each released when taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		bit aw;
		bit w;
		@(posedge CLK);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		bq.push_back(er);
		aw = 0;
		w = 0;
		do begin
			@(posedge CLK);
			if (AWVALID && AWREADY) begin
				AWVALID <= 1'b0;
				aw = 1;
			end
			if (WVALID && WREADY) begin
				WVALID <= 1'b0;
				w = 1;
			end
		end while (!(aw && w));
		while (BVALID !== 1'b1) @(posedge CLK);
	endtask

	task automatic axr(input logic [7:0] a, input logic [33:0] e);
		@(posedge CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		rq.push_back(e);
		do @(posedge CLK); while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		do @(posedge CLK); while (RVALID !== 1'b1);
	endtask

	// hold an event mask for n cycles, one event per cycle
	task automatic ev(input logic [8:0] m, input int n);
		@(posedge CLK);
		evs <= m;
		repeat (n) @(posedge CLK);
		evs <= '0;
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		{NRST, AWVALID, WVALID, ARVALID} = 4'h0;
		{BREADY, RREADY} = 2'h3;
		{AWADDR, ARADDR, WDATA, evs} = '0;
		k = $urandom(32'h9f0c);
		repeat (12) @(posedge CLK);
		NRST <= 1'b1;
		// identity, reset value and an unmapped place
		axr(8'h64, {2'b00, 32'h0000_5a5a});
		axr(8'h00, {2'b00, 32'h0000_0000});
		axr(8'h70, {2'b10, 32'h0000_0000});
		axw(8'h70, 32'h0000_0001, 2'b10);
		$display("test registers done");
		// preset both counters to minus 100 plus 1
		for (int i = 0; i < 2; i++) begin
			axw(8'h20 + 8'(4 * i), 32'hffff_ff9d, 2'b00);
			axw(8'h40 + 8'(4 * i), 32'h0000_00ff, 2'b00);
		end
		// raw event, only counter 0 may interrupt
		axw(8'h00, 32'h0000_0013, 2'b00);
		axw(8'h04, 32'h0000_0011, 2'b00);
		ev(9'h100, 99);
		repeat (4) @(posedge CLK);
		cmp_irq(0);
		axr(8'h60, {2'b00, 32'h0000_0003});
		ev(9'h100, 1);
		repeat (4) @(posedge CLK);
		cmp_irq(1);
		axr(8'h20, {2'b00, 32'h0000_0001});
		axw(8'h00, 32'h0000_0000, 2'b00);
		axw(8'h04, 32'h0000_0000, 2'b00);
		axr(8'h60, {2'b00, 32'h0000_0003});
		axw(8'h60, 32'h0000_0001, 2'b00);
		axr(8'h60, {2'b00, 32'h0000_0002});
		$display("test overflow done");
		// forced overflow from a zero count
		axw(8'h08, 32'h0000_0017, 2'b00);
		k = $urandom_range(4, 2);
		repeat (k) ev(9'h100, 1);
		repeat (4) @(posedge CLK);
		cmp_irq(1 + k);
		axw(8'h08, 32'h0000_0000, 2'b00);
		$display("test force done");
		// one counter per mechanism, cleared, in retire mode
		foreach (sel[i]) begin
			axw(8'h20 + 8'(4 * i), 32'h0000_0000, 2'b00);
			axw(8'h40 + 8'(4 * i), 32'h0000_0000, 2'b00);
			axw(8'(4 * i), {25'h0, sel[i], 4'h9}, 2'b00);
		end
		h = $urandom_range(3, 1);
		foreach (seq[j]) ev(seq[j], (seq[j] == 9'h040) ? h : 1);
		foreach (sel[i]) axr(8'h20 + 8'(4 * i), {2'b00, 32'(cnt_e[i])});
		// untagged retired instructions added on counter 3
		axw(8'h0c, {25'h0, pcort_pkg::PCORT_EV_INSTR, 4'h1}, 2'b00);
		ev(9'h001, 2);
		axr(8'h2c, {2'b00, 32'h0000_0005});
		// outside retire mode a cancelled tagged op still counts
		axw(8'h00, {25'h0, pcort_pkg::PCORT_EV_FRONT, 4'h1}, 2'b00);
		ev(9'h080, 1);
		ev(9'h040, h);
		ev(9'h002, 1);
		axr(8'h20, {2'b00, 32'h0000_0002});
		cmp_irq(1 + k);
		$display("test tagging done");
		// let the last read reach the scoreboard first
		@(posedge CLK);
		give_verdict();
	end
endmodule // pcort_top_bench
